// file: common/rsfe_pkg.sv
/*
 * Constants for the serial-line slave receive framer: character and
 * frame sizes, silent-interval lengths, check-value constants,
 * exception codes and error-cause values.
 * Assumes nothing of its surroundings; every design file imports it.
 */
package rsfe_pkg;

  localparam int          CHAR_BITS    = 11;
  localparam int          DATA_BITS    = 8;
  localparam int          RX_BITS      = 10;
  // Silent intervals in half-bit units: 1.5 and 3.5 character times.
  localparam int          T15_HALF     = 33;
  localparam int          T35_HALF     = 77;
  // Gap is timed from the middle of the last stop bit, half a bit early.
  localparam int          TAIL_HALF    = 1;
  localparam int          MIN_FRAME    = 4;
  localparam int          MAX_FRAME    = 256;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          FIFO_WIDTH   = 9;
  localparam int          GAP_W        = 23;
  localparam int          CNT_W        = 9;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'hA001;
  localparam logic [7:0]  EXC_FLAG     = 8'h80;
  localparam logic [7:0]  EXC_NONE     = 8'h00;
  localparam logic [7:0]  EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0]  EXC_ILL_VAL  = 8'h03;
  localparam logic [7:0]  EXC_DEV_FAIL = 8'h04;

  localparam logic [3:0]  CAUSE_NONE       = 4'h0;
  localparam logic [3:0]  CAUSE_BAD_VALUE  = 4'h1;
  localparam logic [3:0]  CAUSE_BAD_SET    = 4'h2;
  localparam logic [3:0]  CAUSE_WRITE_ONLY = 4'h3;
  localparam logic [3:0]  CAUSE_READ_ONLY  = 4'h4;
  localparam logic [3:0]  CAUSE_NV_READ    = 4'h5;
  localparam logic [3:0]  CAUSE_NV_WRITE   = 4'h6;
  localparam logic [3:0]  CAUSE_NV_CHKSUM  = 4'h7;
  localparam logic [3:0]  CAUSE_RUNNING    = 4'h8;
  localparam logic [3:0]  CAUSE_SETS_DIFF  = 4'h9;
  localparam logic [3:0]  CAUSE_BAD_TYPE   = 4'hA;
  localparam logic [3:0]  CAUSE_UNKNOWN_P  = 4'hB;
  localparam logic [3:0]  CAUSE_TEL_CHKSUM = 4'hC;
  localparam logic [3:0]  CAUSE_TEL_SYNTAX = 4'hD;
  localparam logic [3:0]  CAUSE_TYPE_COUNT = 4'hE;
  localparam logic [3:0]  CAUSE_UNKNOWN    = 4'hF;

  typedef enum {RX_IDLE, RX_START, RX_DATA} rsfe_rx_t;

endpackage : rsfe_pkg

// file: logic/rsfe_fifo.sv
/*
 * Synchronous FIFO with a registered output stage.
 * Assumes one clock and a synchronous active-high reset; the memory holds
 * DEPTH words and the output register one more.
 */
`timescale 1ns/100ps
module rsfe_fifo #(
  parameter int WIDTH = rsfe_pkg::FIFO_WIDTH,
  parameter int DEPTH = rsfe_pkg::FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  import rsfe_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign push    = inValid && inReady;
  // The output register refills whenever it is empty or being drained.
  assign pop     = (count_q != '0) && (!outValid || outReady);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      outValid <= 1'b0;
      outData  <= '0;
    end else if (pop) begin
      outValid <= 1'b1;
      outData  <= mem[rdPtr_q];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

endmodule : rsfe_fifo

// file: logic/rsfe_framer.sv
/*
 * Receive framer and exception encoder for a serial-line slave in RTU
 * mode. Characters are sampled from the line, frames are delimited by
 * silent intervals, checked and streamed through a FIFO followed by a
 * status word; handler verdicts are turned into exception responses.
 * Assumes one 100 MHz clock, a synchronous reset, and a handler that
 * judges each accepted frame once.
 */
`timescale 1ns/100ps
// Function
// (R1) Unsupported function or sub-function gives code 1
// (R2) Bad register count or parameter gives code 2
// (R3) Bad data set or byte count gives code 3
// (R4) Failed access gives code 4, cause stored
// (R5) Cause values 0 to 7 as encoded
// (R6) Cause values 8 to 15 as encoded
// (R7) Reading cause returns it and clears it
// (R8) All stations share mode and port settings
// (R9) Eleven-bit character, eight data bits LSB first
// (R10) Without parity a second stop bit follows
// (R11) Frame of four to 256 bytes
// (R12) Silence of 3.5 characters ends a frame
// (R13) Gap over 1.5 characters discards the frame
// (R14) Characters of a frame follow back to back
// (R15) Check register preset FFFF, polynomial A001
// (R16) Check bytes last, low byte first
// (R17) Exception echoes function with 0x80 set
// (R18) Errored frames get no response
// (R19) Gap counter from baud rate, restarts per character
module rsfe_framer #(
  parameter int DEPTH = rsfe_pkg::FIFO_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        rxPin,
  input  wire logic [15:0] bitCycles,
  input  wire logic        parityEn,
  input  wire logic        parityOdd,
  output logic       [7:0] outData,
  output logic             outStatus,
  output logic             outValid,
  input  wire logic        outReady,
  output logic             frameDone,
  output logic             frameOk,
  input  wire logic        chkValid,
  input  wire logic        funcSupported,
  input  wire logic        subFuncOk,
  input  wire logic        regCountOne,
  input  wire logic        paramKnown,
  input  wire logic        typeMatch,
  input  wire logic        dataSetOk,
  input  wire logic        byteCountOk,
  input  wire logic        fixedFieldsOk,
  input  wire logic        accessOk,
  input  wire logic  [3:0] failCause,
  output logic             rspValid,
  output logic       [7:0] rspFunc,
  output logic       [7:0] rspCode,
  input  wire logic        causeRead,
  output logic       [3:0] causeData
);
  import rsfe_pkg::*;

  function automatic logic [15:0] crcByte(input logic [15:0] crc,
                                          input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < DATA_BITS; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crcByte

  rsfe_rx_t             rxState_q;
  logic                 rxMeta_q;
  logic                 rxSync_q;
  logic [15:0]          bitCnt_q;
  logic [3:0]           bitIdx_q;
  logic [RX_BITS-1:0]   shift_q;
  logic [RX_BITS-1:0]   rxWord;
  logic                 rxDone;
  logic                 charErr;
  logic                 charStart;
  logic [GAP_W-1:0]     gap_q;
  logic [GAP_W-1:0]     t15Cyc;
  logic [GAP_W-1:0]     t35Cyc;
  logic                 gapLong;
  logic                 frameEnd;
  logic                 inFrame_q;
  logic [CNT_W-1:0]     byteCnt_q;
  logic [15:0]          crc_q;
  logic                 bad_q;
  logic                 late_q;
  logic                 ok;
  logic                 statPend_q;
  logic                 statOk_q;
  logic                 fifoInReady;
  logic                 fifoInValid;
  logic                 pushOk;
  logic [FIFO_WIDTH-1:0] fifoInData;
  logic [FIFO_WIDTH-1:0] fifoOutData;
  logic [7:0]           funcHold_q;
  logic                 armed_q;
  logic                 chkAcc;
  logic [7:0]           excCode;
  logic [3:0]           cause_q;
  logic                 causeSet;

  // The line is asynchronous to core_clk; only rxSync_q is used below.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
    end else begin
      rxMeta_q <= rxPin;
      rxSync_q <= rxMeta_q;
    end
  end

  // Each bit is sampled in its middle; a start bit that has gone high
  // again by mid-bit is taken for a glitch and dropped.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rxState_q <= RX_IDLE;
      bitCnt_q  <= 16'h0000;
      bitIdx_q  <= 4'h0;
      shift_q   <= '0;
    end else begin
      case (rxState_q)
        RX_IDLE: begin
          if (!rxSync_q) begin
            rxState_q <= RX_START;
            bitCnt_q  <= bitCycles >> 1;
          end
        end
        RX_START: begin
          if (bitCnt_q == 16'h0000) begin
            rxState_q <= rxSync_q ? RX_IDLE : RX_DATA;
            bitCnt_q  <= bitCycles - 16'h0001;
            bitIdx_q  <= 4'h0;
          end else begin
            bitCnt_q <= bitCnt_q - 16'h0001;
          end
        end
        RX_DATA: begin
          if (bitCnt_q == 16'h0000) begin
            shift_q  <= rxWord; // R9
            bitCnt_q <= bitCycles - 16'h0001;
            bitIdx_q <= bitIdx_q + 4'h1;
            if (bitIdx_q == 4'(RX_BITS - 1)) begin
              rxState_q <= RX_IDLE;
            end
          end else begin
            bitCnt_q <= bitCnt_q - 16'h0001;
          end
        end
        default: begin
          rxState_q <= RX_IDLE;
        end
      endcase
    end
  end

  assign rxWord = {rxSync_q, shift_q[RX_BITS-1:1]};
  assign rxDone = (rxState_q == RX_DATA) && (bitCnt_q == 16'h0000) &&
                  (bitIdx_q == 4'(RX_BITS - 1));
  // Gaps are judged at the next start edge, before the counter restarts.
  assign charStart = (rxState_q == RX_IDLE) && !rxSync_q;
  // Bit 8 is parity, or a second stop bit when parity is off.
  assign charErr = !rxWord[9] ||
                   (parityEn ? ((^rxWord[8:0]) != parityOdd) // R8
                             : !rxWord[8]); // R10

  // Thresholds scale with the configured bit time, so any baud rate that
  // all stations agree on is timed correctly.
  assign t15Cyc = GAP_W'((32'(bitCycles) * (T15_HALF + TAIL_HALF)) >> 1);
  assign t35Cyc = GAP_W'((32'(bitCycles) * (T35_HALF + TAIL_HALF)) >> 1);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      gap_q <= '0;
    end else if (rxState_q != RX_IDLE) begin
      gap_q <= '0; // R19
    end else if (gap_q != '1) begin
      gap_q <= gap_q + 1'b1; // R19
    end
  end

  assign gapLong  = gap_q > t15Cyc;
  assign frameEnd = inFrame_q && (rxState_q == RX_IDLE) &&
                    (gap_q == t35Cyc); // R12
  // A byte is refused while the FIFO is full or a status word waits.
  assign pushOk   = fifoInReady && !statPend_q;
  assign ok = !bad_q && !late_q && (crc_q == 16'h0000) && // R16
              (byteCnt_q >= CNT_W'(MIN_FRAME)) &&
              (byteCnt_q <= CNT_W'(MAX_FRAME)); // R11

  always_ff @(posedge core_clk) begin
    if (srst) begin
      inFrame_q <= 1'b0;
      byteCnt_q <= '0;
      crc_q     <= CRC_INIT;
      bad_q     <= 1'b0;
      late_q    <= 1'b0;
    end else if (frameEnd) begin
      inFrame_q <= 1'b0;
    end else if (rxDone && !inFrame_q) begin
      inFrame_q <= 1'b1;
      byteCnt_q <= CNT_W'(1);
      crc_q     <= crcByte(CRC_INIT, rxWord[7:0]); // R15
      bad_q     <= charErr || !pushOk;
      late_q    <= 1'b0;
    end else if (rxDone) begin
      if (byteCnt_q <= CNT_W'(MAX_FRAME)) begin
        byteCnt_q <= byteCnt_q + 1'b1;
      end
      crc_q  <= crcByte(crc_q, rxWord[7:0]); // R15
      bad_q  <= bad_q || charErr || !pushOk;
    end else if (charStart && inFrame_q && gapLong) begin
      late_q <= 1'b1; // R13 R14
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      funcHold_q <= 8'h00;
    end else if (rxDone && inFrame_q && (byteCnt_q == CNT_W'(1))) begin
      funcHold_q <= rxWord[7:0];
    end
  end

  // The status word trails the frame's bytes so the consumer can drop a
  // rejected frame it has already partly taken in.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      statPend_q <= 1'b0;
      statOk_q   <= 1'b0;
    end else if (frameEnd) begin
      statPend_q <= 1'b1;
      statOk_q   <= ok; // R13
    end else if (fifoInReady) begin
      statPend_q <= 1'b0;
    end
  end

  assign fifoInValid = statPend_q || (rxDone && pushOk);
  assign fifoInData  = statPend_q ? {1'b1, 7'h00, statOk_q}
                                  : {1'b0, rxWord[7:0]};

  rsfe_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .srst     (srst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (fifoOutData)
  );

  assign outData   = fifoOutData[7:0];
  assign outStatus = fifoOutData[8];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frameDone <= 1'b0;
      frameOk   <= 1'b0;
    end else begin
      frameDone <= frameEnd;
      frameOk   <= frameEnd && ok;
    end
  end

  // Only a clean frame arms the encoder, so errored frames never answer.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      armed_q <= 1'b0;
    end else if (frameEnd) begin
      armed_q <= ok; // R18
    end else if (chkAcc) begin
      armed_q <= 1'b0;
    end
  end

  assign chkAcc = chkValid && armed_q;

  always_comb begin
    if (!funcSupported || !subFuncOk) begin
      excCode = EXC_ILL_FUNC; // R1
    end else if (!regCountOne || !paramKnown || !typeMatch) begin
      excCode = EXC_ILL_ADDR; // R2
    end else if (!dataSetOk || !byteCountOk || !fixedFieldsOk) begin
      excCode = EXC_ILL_VAL; // R3
    end else if (!accessOk) begin
      excCode = EXC_DEV_FAIL; // R4
    end else begin
      excCode = EXC_NONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rspValid <= 1'b0;
      rspFunc  <= 8'h00;
      rspCode  <= 8'h00;
    end else begin
      rspValid <= chkAcc && (excCode != EXC_NONE);
      if (chkAcc) begin
        rspFunc <= funcHold_q | EXC_FLAG; // R17
        rspCode <= excCode;
      end
    end
  end

  assign causeSet = chkAcc && (excCode == EXC_DEV_FAIL);

  // A new failure in the same cycle as a read wins over the clear.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cause_q   <= CAUSE_NONE;
      causeData <= CAUSE_NONE;
    end else begin
      if (causeSet) begin
        cause_q <= failCause; // R4 R5 R6
      end else if (causeRead) begin
        cause_q <= CAUSE_NONE; // R7
      end
      if (causeRead) begin
        causeData <= cause_q; // R7
      end
    end
  end

  property p_exc1;
    @(posedge core_clk) disable iff (srst)
    chkAcc && !funcSupported |=> rspValid && rspCode == EXC_ILL_FUNC;
  endproperty
  a_exc1: assert property (p_exc1) else $error("code 1 missing"); // R1

  property p_exc2;
    @(posedge core_clk) disable iff (srst)
    chkAcc && funcSupported && subFuncOk && !paramKnown
      |=> rspValid && rspCode == EXC_ILL_ADDR;
  endproperty
  a_exc2: assert property (p_exc2) else $error("code 2 missing"); // R2

  property p_exc3;
    @(posedge core_clk) disable iff (srst)
    chkAcc && funcSupported && subFuncOk && regCountOne && paramKnown &&
      typeMatch && !byteCountOk |=> rspValid && rspCode == EXC_ILL_VAL;
  endproperty
  a_exc3: assert property (p_exc3) else $error("code 3 missing"); // R3

  property p_cause;
    @(posedge core_clk) disable iff (srst)
    causeSet |=> cause_q == $past(failCause) && rspCode == EXC_DEV_FAIL;
  endproperty
  a_cause: assert property (p_cause) else $error("cause not kept"); // R4

  property p_clear;
    @(posedge core_clk) disable iff (srst)
    causeRead && !causeSet
      |=> cause_q == CAUSE_NONE && causeData == $past(cause_q);
  endproperty
  a_clear: assert property (p_clear) else $error("cause not cleared"); // R7

  property p_msb;
    @(posedge core_clk) disable iff (srst)
    chkAcc ##1 rspValid |-> rspFunc == ($past(funcHold_q) | EXC_FLAG);
  endproperty
  a_msb: assert property (p_msb) else $error("function echo wrong"); // R17

  property p_noRsp;
    @(posedge core_clk) disable iff (srst)
    frameDone && !frameOk |-> !armed_q ##1 !rspValid;
  endproperty
  a_noRsp: assert property (p_noRsp) else $error("errored frame armed"); // R18

  property p_late;
    @(posedge core_clk) disable iff (srst)
    charStart && inFrame_q && gapLong && !frameEnd |=> late_q;
  endproperty
  a_late: assert property (p_late) else $error("late byte missed"); // R13

  property p_end;
    @(posedge core_clk) disable iff (srst)
    frameEnd |=> frameDone && !inFrame_q && statPend_q;
  endproperty
  a_end: assert property (p_end) else $error("frame end lost"); // R12

  property p_good;
    @(posedge core_clk) disable iff (srst)
    frameOk |-> $past(crc_q) == 16'h0000 && !$past(late_q);
  endproperty
  a_good: assert property (p_good) else $error("bad frame passed"); // R15

endmodule : rsfe_framer

// file: tb/rsfe_line_master.sv
/*
 * Behavioural model of the bus master that drives the serial line into
 * the framer: character timing, parity, check bytes and frame gaps.
 * Assumes the testbench fills frm and calls send_frame between frames;
 * the model drives the line high itself, so it rests high outside characters.
 */
`timescale 1ns/100ps
module rsfe_line_master #(
  parameter int BIT_CYC = 8
) (
  input  wire logic core_clk,
  input  wire logic parityEn,
  input  wire logic parityOdd,
  output logic      rxPin
);
  logic [7:0] frm[$];
  logic [7:0] sent[$];

  initial begin
    rxPin = 1'b1;
  end

  task automatic hold_bit(input logic v);
    rxPin = v;
    repeat (BIT_CYC) @(posedge core_clk);
    #1;
  endtask : hold_bit

  task automatic send_byte(input logic [7:0] b, input bit parErr);
    hold_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      hold_bit(b[i]);
    end
    if (parityEn) begin
      hold_bit(^b ^ parityOdd ^ parErr);
    end else begin
      hold_bit(1'b1 ^ parErr);
    end
    hold_bit(1'b1);
  endtask : send_byte

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int j = 0; j < 8; j++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  // A gap index of -1 keeps the frame contiguous; otherwise 20 idle bits
  // follow that byte, longer than 1.5 but shorter than 3.5 characters.
  task automatic send_frame(input bit crcErr,
                            input bit parErr,
                            input int gapIdx);
    logic [15:0] c;
    c = crc16(frm) ^ {15'h0000, crcErr};
    sent = frm;
    sent.push_back(c[7:0]);
    sent.push_back(c[15:8]);
    @(posedge core_clk);
    #1;
    foreach (sent[i]) begin
      send_byte(sent[i], parErr && (i == 1));
      if (i == gapIdx) begin
        repeat (20) hold_bit(1'b1);
      end
    end
  endtask : send_frame
endmodule : rsfe_line_master

// file: tb/tb.sv
/*
 * Self-checking testbench for the receive framer and exception encoder.
 * Assumes the package, FIFO and framer are compiled first, and a line
 * master model that sends whole frames on request.
 */
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module tb;
  import rsfe_pkg::*;
  localparam int BIT_CYC = 8;
  logic       core_clk;
  logic       srst;
  wire        rxPin;
  logic       parityEn;
  logic       parityOdd;
  logic [7:0] outData;
  logic       outStatus;
  logic       outValid;
  logic       outReady;
  logic       frameDone;
  logic       frameOk;
  logic       chkValid;
  logic [8:0] okVec;
  logic [3:0] failCause;
  logic       rspValid;
  logic [7:0] rspFunc;
  logic [7:0] rspCode;
  logic       causeRead;
  logic [3:0] causeData;
  logic [7:0] dataQ[$];
  logic [7:0] statQ[$];
  int         mismatches;
  int         checked;

  rsfe_framer u_rsfe_framer (
    .core_clk(core_clk), .srst(srst), .rxPin(rxPin),
    .bitCycles(16'(BIT_CYC)), .parityEn(parityEn), .parityOdd(parityOdd),
    .outData(outData), .outStatus(outStatus), .outValid(outValid),
    .outReady(outReady), .frameDone(frameDone), .frameOk(frameOk),
    .chkValid(chkValid), .funcSupported(okVec[8]), .subFuncOk(okVec[7]),
    .regCountOne(okVec[6]), .paramKnown(okVec[5]), .typeMatch(okVec[4]),
    .dataSetOk(okVec[3]), .byteCountOk(okVec[2]),
    .fixedFieldsOk(okVec[1]), .accessOk(okVec[0]), .failCause(failCause),
    .rspValid(rspValid), .rspFunc(rspFunc), .rspCode(rspCode),
    .causeRead(causeRead), .causeData(causeData)
  );

  rsfe_line_master #(.BIT_CYC(BIT_CYC)) u_rsfe_line_master (
    .core_clk(core_clk), .parityEn(parityEn), .parityOdd(parityOdd),
    .rxPin(rxPin)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (!srst && outValid === 1'b1 && outReady === 1'b1) begin
      if (outStatus) begin
        statQ.push_back(outData);
      end else begin
        dataQ.push_back(outData);
      end
    end
  end

  task automatic complete_run();
    $display("Counts: checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  // Sends a frame of len bytes in total, check bytes included.
  task automatic send(input int len, input logic [7:0] func,
                      input bit crcErr, input bit parErr, input int gapIdx);
    int n;
    u_rsfe_line_master.frm.delete();
    dataQ.delete();
    statQ.delete();
    u_rsfe_line_master.frm.push_back(8'h11);
    if (len > 3) u_rsfe_line_master.frm.push_back(func);
    for (int i = 2; i < len - 2; i++) begin
      u_rsfe_line_master.frm.push_back(8'(i * 37));
    end
    u_rsfe_line_master.send_frame(crcErr, parErr, gapIdx);
    n = 0;
    while (frameDone !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    `CHK(frameDone, 1'b1)
  endtask : send

  task automatic run_frame(input int len, input logic [7:0] func,
                           input bit crcErr, input bit parErr,
                           input int gapIdx, input logic expOk);
    send(len, func, crcErr, parErr, gapIdx);
    `CHK(frameOk, expOk)
    repeat (50) if (statQ.size() == 0) tick();
    `CHK(statQ[0], {7'h00, expOk})
    if (expOk) begin
      `CHK(dataQ.size(), u_rsfe_line_master.sent.size())
      foreach (dataQ[i]) `CHK(dataQ[i], u_rsfe_line_master.sent[i])
    end
  endtask : run_frame

  task automatic test_parity();
    for (int m = 0; m < 3; m++) begin
      parityEn = (m != 0);
      parityOdd = (m == 2);
      run_frame(6, 8'h03, 1'b0, 1'b0, -1, 1'b1);
      run_frame(6, 8'h03, 1'b0, 1'b1, -1, 1'b0);
    end
    parityEn = 1'b1;
    parityOdd = 1'b0;
  endtask : test_parity

  task automatic test_errors();
    run_frame(6, 8'h03, 1'b1, 1'b0, -1, 1'b0);
    chkValid = 1'b1;
    okVec = 9'h0FF;
    tick();
    chkValid = 1'b0;
    okVec = 9'h1FF;
    `CHK(rspValid, 1'b0)
    run_frame(6, 8'h03, 1'b0, 1'b0, 2, 1'b0);
    run_frame(3, 8'h03, 1'b0, 1'b0, -1, 1'b0);
  endtask : test_errors

  // The consumer stalls, so the buffer and its output word fill and the
  // rest of the frame is lost; draining then yields the status word.
  task automatic test_stall();
    outReady = 1'b0;
    send(20, 8'h03, 1'b0, 1'b0, -1);
    `CHK(frameOk, 1'b0)
    `CHK(outValid, 1'b1)
    outReady = 1'b1;
    repeat (60) tick();
    `CHK(dataQ.size(), FIFO_DEPTH + 1)
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      `CHK(dataQ[i], u_rsfe_line_master.sent[i])
    end
    `CHK(statQ[0], 8'h00)
  endtask : test_stall

  task automatic verdict(input logic [7:0] func, input logic [8:0] vec,
                         input logic [3:0] cause, input logic [7:0] code);
    run_frame(4, func, 1'b0, 1'b0, -1, 1'b1);
    chkValid = 1'b1;
    okVec = vec;
    failCause = cause;
    tick();
    chkValid = 1'b0;
    okVec = 9'h1FF;
    `CHK(rspValid, code != 8'h00)
    if (code != 8'h00) begin
      `CHK(rspFunc, func | 8'h80)
      `CHK(rspCode, code)
    end
    tick();
    `CHK(rspValid, 1'b0)
  endtask : verdict

  task automatic test_codes();
    logic [8:0] vec[10] = '{9'h0FF, 9'h17F, 9'h1BF, 9'h1DF, 9'h1EF,
                            9'h1F7, 9'h1FB, 9'h1FD, 9'h0FE, 9'h1FF};
    logic [7:0] code[10] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h02,
                             8'h03, 8'h03, 8'h03, 8'h01, 8'h00};
    for (int i = 0; i < 10; i++) begin
      verdict(8'(8'h05 + i), vec[i], 4'h3, code[i]);
    end
  endtask : test_codes

  task automatic read_cause(input logic [3:0] exp);
    causeRead = 1'b1;
    tick();
    causeRead = 1'b0;
    `CHK(causeData, exp)
    tick();
  endtask : read_cause

  task automatic test_cause();
    read_cause(4'h0);
    for (int c = 1; c < 16; c++) begin
      verdict(8'h64, 9'h1FE, 4'(c), 8'h04);
      read_cause(4'(c));
      read_cause(4'h0);
    end
  endtask : test_cause

  task automatic test_size();
    run_frame(256, 8'h03, 1'b0, 1'b0, -1, 1'b1);
    run_frame(257, 8'h03, 1'b0, 1'b0, -1, 1'b0);
  endtask : test_size

  initial begin
    #1_000_000;
    mismatches++;
    complete_run();
  end

  initial begin
    srst = 1'b1;
    parityEn = 1'b1;
    parityOdd = 1'b0;
    outReady = 1'b1;
    chkValid = 1'b0;
    okVec = 9'h1FF;
    failCause = 4'h0;
    causeRead = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    // The line must rest for a full frame gap before the first frame.
    repeat (400) tick();
    test_parity();
    test_errors();
    test_stall();
    test_codes();
    test_cause();
    test_size();
    complete_run();
  end
endmodule : tb
